// ---- core/lock_detector.sv ----
// lock detector: counts consecutive reference periods with a good window
// assumes ref_tick and window_ok come from logic on sys_clk, one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
module lock_detector #(
    parameter int CNT_W = 10
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic [1:0] lock_count_select,
    input wire logic ref_tick,
    input wire logic window_ok,
    output logic locked
);
    import rx_synth_pkg::*;

    logic [CNT_W-1:0] count_q, count_d;
    logic locked_q, locked_d;
    logic [CNT_W-1:0] target;

    // ------------------------------------------------------------
    // consecutive good-period counter
    // ------------------------------------------------------------
    // threshold from select
    assign target = CNT_W'(1) << (LOCK_COUNT_BASE_LOG2 + int'(lock_count_select));

    always_comb begin
        count_d = count_q;
        locked_d = locked_q;
        if (!enable) begin
            count_d = '0;
            locked_d = 1'b0;
        end else if (ref_tick) begin
            if (!window_ok) begin
                // one missed window restarts the run and drops lock
                count_d = '0;
                locked_d = 1'b0;
            end else if ({1'b0, count_q} + 1'b1 >= {1'b0, target}) begin
                count_d = count_q;
                locked_d = 1'b1;
            end else begin
                count_d = count_q + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
            locked_q <= 1'b0;
        end else begin
            count_q <= count_d;
            locked_q <= locked_d;
        end
    end

    assign locked = locked_q;
endmodule
`default_nettype wire

// ---- core/rx_synth_pkg.sv ----
// shared constants and carrier types for the receiver trim and synthesizer registers
// assumes a single 16-bit word register port with 6-bit addresses
package rx_synth_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] RECEIVER_ANALOG_TRIM_ADDR = 6'h17;
    localparam logic [5:0] SYNTH_CONTROL_STATUS_ADDR = 6'h18;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TRIM_RSVD_MSB = 15;
    localparam int TRIM_RSVD_LSB = 14;
    localparam int SYN_LOCK_SEL_LSB = 14;
    localparam int SYN_CAL_DONE_BIT = 13;
    localparam int SYN_CAL_ACTIVE_BIT = 12;
    localparam int SYN_WINDOW_BIT = 11;
    localparam int SYN_LOCK_BIT = 10;
    localparam int SYN_WORD_W = 10;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [13:0] TRIM_RESET = 14'h0a56;   // 0,0,1,0,1,0,01,01,01,10
    localparam logic [1:0] LOCK_SEL_RESET = 2'h1;
    localparam logic WINDOW_RESET = 1'b0;
    localparam logic [9:0] CARRIER_WORD_RESET = 10'h165;  // 357 -> 2405 MHz
    // ------------------------------------------------------------
    // synthesizer timing and frequency plan
    // ------------------------------------------------------------
    localparam int LOCK_COUNT_BASE_LOG2 = 6;         // 64 periods for select 0
    localparam int WINDOW_SHORT_PERIODS = 2;
    localparam int WINDOW_LONG_PERIODS = 4;
    localparam logic [11:0] CARRIER_BASE_MHZ = 12'h800;   // 2048 MHz
    localparam logic [11:0] RX_LO_OFFSET_MHZ = 12'h002;

    typedef struct packed {
        logic bandpass_bias_low_sel;
        logic bandpass_bias_mid_sel;
        logic lna_reduced_in_agc_low;
        logic lna_reduced_in_agc_medium;
        logic mixer_boost_in_agc_high;
        logic mixer_boost_in_agc_medium;
        logic [1:0] lna_varactor_code;
        logic [1:0] mixer_output_current_code;
        logic [1:0] mixer_common_mode_code;
        logic [1:0] mixer_bias_code;
    } trim_t;

    typedef struct packed {
        logic [1:0] lock_count_select;
        logic window_long;
        logic [9:0] carrier_channel_word;
    } synth_cfg_t;
endpackage

// ---- core/rx_trim_and_synth_control.sv ----
// receiver trim and synthesizer control/status register bank
// assumes the serial port front end presents decoded word accesses on sys_clk,
// and that synthesizer status pins arrive asynchronously
// and that reference ticks and window results already come from sys_clk logic
//
// Summary of operation
// - lock declared after 64/128/256/512 consecutive good reference periods
// - lock flag reads 1 in lock, 0 otherwise, resets 0
// - calibration done flag set by calibration, cleared when synthesizer turns on
// - calibration active flag reads 1 while the synced calibration pin is high, two cycles behind the pin
// - window width bit selects 2 or 4 prescaler periods, resets 0
// - carrier word gives 2048 plus word MHz, resets to 357
// - local oscillator at carrier in transmit, 2 MHz lower in receive
// - mid bandpass bias selects 4 or 3.5 uA, resets 0
// - per-AGC gain select bits reset to 1, 0, 1, 0
// - varactor, tail, common-mode reset 1; mixer current resets 2
`timescale 1ns/1ns
`default_nettype none
module rx_trim_and_synth_control #(
    parameter int LOCK_CNT_W = 10
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rdata_valid,
    input wire logic synth_on_pin,
    input wire logic transmit_mode_pin,
    input wire logic cal_active_pin,
    input wire logic ref_tick,
    input wire logic window_ok,
    output rx_synth_pkg::trim_t trim_out,
    output rx_synth_pkg::synth_cfg_t synth_cfg_out,
    output logic [2:0] window_periods,
    output logic [11:0] lo_carrier_channel_word_mhz,
    output logic [11:0] carrier_carrier_channel_word_mhz
);
    import rx_synth_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    // stored register fields
    trim_t trim_q, trim_d;
    synth_cfg_t cfg_q, cfg_d;
    // two-stage synchroniser for the three status pins
    logic [2:0] sync1_q, sync2_q;
    logic synth_on_prev_q, synth_on_prev_d;
    logic cal_done_q, cal_done_d;
    logic cal_prev_q, cal_prev_d;
    // registered read port
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    // derived synthesizer outputs
    logic [2:0] win_q, win_d;
    logic [11:0] lo_q, lo_d;
    logic [11:0] fc_q, fc_d;
    logic synth_on_s, tx_mode_s, cal_active_s;
    logic locked;

    // one decode used for both reads and writes
    function automatic logic hit(input logic [5:0] a, input logic [5:0] reg_off);
        hit = (a == reg_off);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // first stage feeds only the second; status pins are analog-side
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {cal_active_pin, transmit_mode_pin, synth_on_pin};
            sync2_q <= sync1_q;
        end
    end
    // synced pin names, read by all logic below
    assign synth_on_s = sync2_q[0];
    assign tx_mode_s = sync2_q[1];
    assign cal_active_s = sync2_q[2];

    // ------------------------------------------------------------
    // lock detector
    // ------------------------------------------------------------
    // runs only while the synced power pin is high; a missed window
    // or a power-down restarts the count from zero
    // consecutive window count
    lock_detector #(
        .CNT_W(LOCK_CNT_W)
    ) i_lock_detector (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .enable(synth_on_s),
        .lock_count_select(cfg_q.lock_count_select),
        .ref_tick(ref_tick),
        .window_ok(window_ok),
        .locked(locked)
    );

    // ------------------------------------------------------------
    // writable fields
    // ------------------------------------------------------------
    // next values; a write lands on the edge that takes it
    always_comb begin
        trim_d = trim_q;
        cfg_d = cfg_q;
        if (reg_wr_en && hit(reg_addr, RECEIVER_ANALOG_TRIM_ADDR)) begin
            trim_d = trim_t'(reg_wdata[TRIM_RSVD_LSB-1:0]);
        end
        if (reg_wr_en && hit(reg_addr, SYNTH_CONTROL_STATUS_ADDR)) begin
            cfg_d.lock_count_select = reg_wdata[SYN_LOCK_SEL_LSB +: 2];
            cfg_d.window_long = reg_wdata[SYN_WINDOW_BIT];
            cfg_d.carrier_channel_word = reg_wdata[SYN_WORD_W-1:0];
        end
    end

    // async reset loads the power-up trim and synthesizer defaults
    // trim resets
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            trim_q <= trim_t'(TRIM_RESET);
            cfg_q <= '{LOCK_SEL_RESET, WINDOW_RESET, CARRIER_WORD_RESET};
        end else begin
            trim_q <= trim_d;
            cfg_q <= cfg_d;
        end
    end

    // ------------------------------------------------------------
    // calibration status
    // ------------------------------------------------------------
    // edge history of the synced pins and the sticky done flag
    always_comb begin
        synth_on_prev_d = synth_on_s;
        cal_prev_d = cal_active_s;
        cal_done_d = cal_done_q;
        if (synth_on_s && !synth_on_prev_q) begin
            cal_done_d = 1'b0;
        end
        // set wins over a same-cycle clear, so a finished calibration
        // is never lost to a turn-on that lands in the same cycle
        if (cal_prev_q && !cal_active_s) begin
            cal_done_d = 1'b1;
        end
    end

    // calibration status registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            synth_on_prev_q <= 1'b0;
            cal_prev_q <= 1'b0;
            cal_done_q <= 1'b0;
        end else begin
            synth_on_prev_q <= synth_on_prev_d;
            cal_prev_q <= cal_prev_d;
            cal_done_q <= cal_done_d;
        end
    end

    // ------------------------------------------------------------
    // read path and derived synthesizer outputs
    // ------------------------------------------------------------
    // read mux and the derived synthesizer values
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = reg_rd_en;
        if (reg_rd_en) begin
            rdata_d = 16'h0000;
            if (hit(reg_addr, RECEIVER_ANALOG_TRIM_ADDR)) begin
                rdata_d = {2'h0, trim_q};
            end else if (hit(reg_addr, SYNTH_CONTROL_STATUS_ADDR)) begin
                rdata_d = {cfg_q.lock_count_select, cal_done_q, cal_active_s,
                           cfg_q.window_long, locked, cfg_q.carrier_channel_word};
            end
        end
        win_d = cfg_q.window_long ? 3'(WINDOW_LONG_PERIODS) : 3'(WINDOW_SHORT_PERIODS);
        fc_d = CARRIER_BASE_MHZ + {2'h0, cfg_q.carrier_channel_word};
        lo_d = tx_mode_s ? fc_d : fc_d - RX_LO_OFFSET_MHZ;
    end

    // registered so that every output comes from a flip-flop
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
            win_q <= 3'(WINDOW_SHORT_PERIODS);
            // frequency outputs start in step with the reset word, receive side
            fc_q <= CARRIER_BASE_MHZ + {2'h0, CARRIER_WORD_RESET};
            lo_q <= CARRIER_BASE_MHZ + {2'h0, CARRIER_WORD_RESET} - RX_LO_OFFSET_MHZ;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            win_q <= win_d;
            fc_q <= fc_d;
            lo_q <= lo_d;
        end
    end

    // every output below is a register, never logic
    // stored fields out
    assign trim_out = trim_q;
    assign synth_cfg_out = cfg_q;
    assign reg_rdata = rdata_q;
    assign reg_rdata_valid = rvalid_q;
    assign window_periods = win_q;
    assign carrier_carrier_channel_word_mhz = fc_q;
    assign lo_carrier_channel_word_mhz = lo_q;
endmodule
`default_nettype wire

// ---- tb/rx_trim_and_synth_control_asserts.sv ----
// checker for the receiver trim and synthesizer register bank
// assumes it is bound to the bank and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module rx_trim_and_synth_control_asserts (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rdata_valid,
    input wire logic transmit_mode_pin,
    input wire logic cal_active_pin,
    input wire rx_synth_pkg::trim_t trim_out,
    input wire rx_synth_pkg::synth_cfg_t synth_cfg_out,
    input wire logic [2:0] window_periods,
    input wire logic [11:0] lo_carrier_channel_word_mhz,
    input wire logic [11:0] carrier_carrier_channel_word_mhz
);
    import rx_synth_pkg::*;
    wire logic wr_trim = reg_wr_en && reg_addr == RECEIVER_ANALOG_TRIM_ADDR;
    wire logic wr_syn = reg_wr_en && reg_addr == SYNTH_CONTROL_STATUS_ADDR;
    wire logic rd_trim = reg_rd_en && reg_addr == RECEIVER_ANALOG_TRIM_ADDR;
    wire logic rd_syn = reg_rd_en && reg_addr == SYNTH_CONTROL_STATUS_ADDR;
    logic [2:0] up_q;
    // saturating age since reset; hides synchroniser warm-up
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            up_q <= 3'h0;
        else if (up_q != 3'h7)
            up_q <= up_q + 3'h1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    AST_READ_VALID: assert property (reg_rd_en |=> reg_rdata_valid)
        else $error("read valid missing");
    AST_READ_HOLD: assert property (!reg_rd_en |=> !reg_rdata_valid && $stable(reg_rdata))
        else $error("read data moved without a read");
    AST_TRIM_WRITE: assert property (wr_trim |=> trim_out == $past(reg_wdata[13:0]))
        else $error("trim write not applied");
    AST_SYN_WRITE: assert property (wr_syn |=> synth_cfg_out ==
        {$past(reg_wdata[15:14]), $past(reg_wdata[11]), $past(reg_wdata[9:0])})
        else $error("synth write not applied");
    AST_TRIM_READ: assert property (rd_trim |=> reg_rdata == {2'h0, $past(trim_out)})
        else $error("trim read wrong");
    AST_SYN_READ: assert property (rd_syn |=>
        {reg_rdata[15:14], reg_rdata[11], reg_rdata[9:0]} == $past(synth_cfg_out))
        else $error("synth read wrong");
    AST_CARRIER: assert property (carrier_carrier_channel_word_mhz ==
        CARRIER_BASE_MHZ + {2'h0, $past(synth_cfg_out.carrier_channel_word)})
        else $error("carrier frequency wrong");
    AST_WINDOW: assert property (window_periods ==
        ($past(synth_cfg_out.window_long) ? 3'h4 : 3'h2))
        else $error("window width wrong");
    AST_LO: assert property ((up_q == 3'h7 && $stable(transmit_mode_pin))[*4] |->
        lo_carrier_channel_word_mhz == carrier_carrier_channel_word_mhz - (transmit_mode_pin ? 12'h0 : RX_LO_OFFSET_MHZ))
        else $error("local oscillator wrong");
    AST_CAL_ACTIVE: assert property ((up_q == 3'h7 && $stable(cal_active_pin))[*4]
        ##0 rd_syn |=> reg_rdata[SYN_CAL_ACTIVE_BIT] == $past(cal_active_pin))
        else $error("calibration active flag wrong");
    cover property (wr_trim);
    cover property (rd_syn ##1 reg_rdata[SYN_LOCK_BIT]);
    cover property (rd_syn ##1 reg_rdata[SYN_CAL_DONE_BIT]);
endmodule
bind rx_trim_and_synth_control rx_trim_and_synth_control_asserts i_rx_trim_and_synth_control_asserts (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .transmit_mode_pin(transmit_mode_pin),
    .cal_active_pin(cal_active_pin), .trim_out(trim_out), .synth_cfg_out(synth_cfg_out),
    .window_periods(window_periods), .lo_carrier_channel_word_mhz(lo_carrier_channel_word_mhz),
    .carrier_carrier_channel_word_mhz(carrier_carrier_channel_word_mhz));
`default_nettype wire

// ---- tb/rx_trim_and_synth_control_tb_top.sv ----
// self-checking bench for the receiver trim and synthesizer register bank
// assumes the bank alone, driven straight at its ports on sys_clk
`timescale 1ns/1ns
`default_nettype none
module rx_trim_and_synth_control_tb_top;
    import rx_synth_pkg::*;
    localparam logic [5:0] TRM = RECEIVER_ANALOG_TRIM_ADDR;
    localparam logic [5:0] SYN = SYNTH_CONTROL_STATUS_ADDR;
    logic sys_clk = 1'b0, reset_n = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
    logic synth_on_pin = 1'b0, transmit_mode_pin = 1'b0, cal_active_pin = 1'b0;
    logic ref_tick = 1'b0, window_ok = 1'b0, reg_rdata_valid;
    logic [5:0] reg_addr = 6'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    trim_t trim_out;
    synth_cfg_t synth_cfg_out;
    logic [2:0] window_periods;
    logic [11:0] lo_carrier_channel_word_mhz, carrier_carrier_channel_word_mhz;
    int n_fail = 0, checked = 0, cyc = 0;
    rx_trim_and_synth_control i_rx_trim_and_synth_control (.sys_clk(sys_clk),
        .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
        .synth_on_pin(synth_on_pin), .transmit_mode_pin(transmit_mode_pin),
        .cal_active_pin(cal_active_pin), .ref_tick(ref_tick), .window_ok(window_ok),
        .trim_out(trim_out), .synth_cfg_out(synth_cfg_out), .window_periods(window_periods),
        .lo_carrier_channel_word_mhz(lo_carrier_channel_word_mhz), .carrier_carrier_channel_word_mhz(carrier_carrier_channel_word_mhz));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic complete_run;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard, far above the roughly 1100 cycles needed
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 8000) begin
            n_fail++;
            complete_run;
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
        idle(2);
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge sys_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        #1;
        check({15'h0, reg_rdata_valid}, 16'h0001);
        check(reg_rdata & m, e);
    endtask
    // status pins are asynchronous; give the synchronisers time
    task automatic pins(input logic on, input logic tx, input logic cal);
        @(posedge sys_clk);
        synth_on_pin <= on;
        transmit_mode_pin <= tx;
        cal_active_pin <= cal;
        idle(6);
    endtask
    task automatic ticks(input int n, input logic ok);
        repeat (n) begin
            @(posedge sys_clk);
            ref_tick <= 1'b1;
            window_ok <= ok;
            @(posedge sys_clk);
            ref_tick <= 1'b0;
        end
        idle(3);
    endtask
    task automatic outs(input logic [11:0] c, input logic [11:0] lo, input logic [2:0] w);
        check({4'h0, carrier_carrier_channel_word_mhz}, {4'h0, c});
        check({4'h0, lo_carrier_channel_word_mhz}, {4'h0, lo});
        check({13'h0, window_periods}, {13'h0, w});
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        idle(3);
        rd_chk(TRM, 16'hffff, 16'h0a56);
        rd_chk(SYN, 16'hffff, 16'h4165);
        check({2'h0, trim_out}, 16'h0a56);
        check({3'h0, synth_cfg_out}, 16'h0965);
        outs(12'h965, 12'h963, 3'h2);
        $display("test reset values done");
        wr(TRM, 16'h3fff);
        check({2'h0, trim_out}, 16'h3fff);
        rd_chk(TRM, 16'hffff, 16'h3fff);
        wr(TRM, 16'h2000);
        check({2'h0, trim_out}, 16'h2000);
        wr(6'h19, 16'hffff);
        rd_chk(6'h00, 16'hffff, 16'h0000);
        rd_chk(TRM, 16'hffff, 16'h2000);
        $display("test trim register done");
        pins(1'b0, 1'b1, 1'b0);
        wr(SYN, 16'hffff);
        check({3'h0, synth_cfg_out}, 16'h1fff);
        rd_chk(SYN, 16'hffff, 16'hcbff);
        outs(12'hbff, 12'hbff, 3'h4);
        pins(1'b0, 1'b0, 1'b0);
        wr(SYN, 16'h0000);
        check({3'h0, synth_cfg_out}, 16'h0000);
        outs(12'h800, 12'h7fe, 3'h2);
        $display("test synth config done");
        pins(1'b1, 1'b0, 1'b1);
        rd_chk(SYN, 16'h3000, 16'h1000);
        pins(1'b1, 1'b0, 1'b0);
        rd_chk(SYN, 16'h3000, 16'h2000);
        rd_chk(SYN, 16'h3000, 16'h2000);
        pins(1'b0, 1'b0, 1'b0);
        pins(1'b1, 1'b0, 1'b0);
        rd_chk(SYN, 16'h3000, 16'h0000);
        $display("test calibration flags done");
        ticks(63, 1'b1);
        rd_chk(SYN, 16'h0400, 16'h0000);
        ticks(1, 1'b1);
        rd_chk(SYN, 16'h0400, 16'h0400);
        ticks(1, 1'b0);
        rd_chk(SYN, 16'h0400, 16'h0000);
        wr(SYN, 16'h4000);
        ticks(127, 1'b1);
        rd_chk(SYN, 16'h0400, 16'h0000);
        ticks(1, 1'b1);
        rd_chk(SYN, 16'h0400, 16'h0400);
        pins(1'b0, 1'b0, 1'b0);
        ticks(1, 1'b1);
        rd_chk(SYN, 16'h0400, 16'h0000);
        pins(1'b1, 1'b0, 1'b0);
        wr(SYN, 16'h8000);
        ticks(255, 1'b1);
        rd_chk(SYN, 16'h0400, 16'h0000);
        ticks(1, 1'b1);
        rd_chk(SYN, 16'h0400, 16'h0400);
        $display("test lock detector done");
        complete_run;
    end
endmodule
`default_nettype wire
